/* File: inc/wdtts_pkg.sv */
package wdtts_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDTTS_OFF_LOAD   = 8'h00;
  localparam logic [7:0] WDTTS_OFF_VALUE  = 8'h04;
  localparam logic [7:0] WDTTS_OFF_CTRL   = 8'h08;
  localparam logic [7:0] WDTTS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] WDTTS_OFF_MASK   = 8'h10;
  localparam logic [7:0] WDTTS_OFF_MSTAT  = 8'h14;
  localparam logic [7:0] WDTTS_OFF_LOCK   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WDTTS_CTRL_EN_BIT    = 0;
  localparam int WDTTS_CTRL_RSTEN_BIT = 1;
  localparam int WDTTS_CTRL_STALL_BIT = 2;
  localparam int WDTTS_ST_TMO_BIT     = 0;
  localparam int WDTTS_ST_RST_BIT     = 1;
  localparam int WDTTS_NUM_EVT        = 2;

  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [31:0] WDTTS_LOAD_RST   = 32'hFFFFFFFF;
  localparam logic [31:0] WDTTS_UNLOCK_KEY = 32'h1ACCE551;
  localparam logic [1:0]  WDTTS_MASK_RST   = 2'h0;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } wdtts_req_type;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } wdtts_rsp_type;

endpackage

/* File: rtl/wdtts_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module wdtts_irq
  import wdtts_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic [WDTTS_NUM_EVT-1:0] event_i,
  input  wire logic [WDTTS_NUM_EVT-1:0] clear_i,
  input  wire logic                     mask_we_i,
  input  wire logic [WDTTS_NUM_EVT-1:0] mask_d_i,
  output logic      [WDTTS_NUM_EVT-1:0] status_o,
  output logic      [WDTTS_NUM_EVT-1:0] mask_o,
  output logic                          irq_o
);

  // ----------------------------------------------------------------
  // Sticky status, set wins over clear
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WDTTS_NUM_EVT; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (!resetn_i)
          status_o[g] <= 1'b0;
        else if (event_i[g])
          status_o[g] <= 1'b1;
        else if (clear_i[g])
          status_o[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      mask_o <= WDTTS_MASK_RST;
    else if (mask_we_i)
      mask_o <= mask_d_i;
  end

  assign irq_o = |(status_o & mask_o);

endmodule
`default_nettype wire

/* File: rtl/wdtts_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module wdtts_counter
  import wdtts_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_value_i,
  output logic      [31:0] count_o,
  output logic             zero_o
);

  // ----------------------------------------------------------------
  // Down counter with reload
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      count_o <= WDTTS_LOAD_RST;
    else if (load_i)
      count_o <= load_value_i;
    else if (run_i && count_o != 32'h00000000)
      count_o <= count_o - 32'h00000001;
  end

  assign zero_o = run_i && (count_o == 32'h00000000);

endmodule
`default_nettype wire

/* File: rtl/wdtts_top.sv */
// Notes on behaviour
// - On first reaching zero the counter reloads the programmed load value.
// - A load write while running copies the value into the counter at once.
// - A load write of zero raises the timeout interrupt immediately.
// - While locked, writes to enable, load and reset enable are ignored.
// - Writing the unlock key restores write access to the configuration.
// - Reset enable decides whether a second timeout resets the processor.
// - With stall on, the counter holds while the debugger halts the core.
// - With stall off, the counter keeps counting during debug halt.
// - Software can read whether the counter is enabled.
// - Software can read the live counter value at any time.
// - The 32-bit counter counts down and interrupts at its first zero.
// - Enabling the counter also enables the timeout interrupt.
// - A second zero with interrupt pending and reset on asserts reset.
// - Clearing the interrupt reloads the counter and resumes counting.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdtts_top
  import wdtts_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  read_i,
  input  wire logic                  write_i,
  input  wire logic [7:0]            address_i,
  input  wire logic [31:0]           writedata_i,
  input  wire logic [3:0]            byteenable_i,
  output logic      [31:0]           readdata_o,
  output logic                       waitrequest_o,
  output logic      [1:0]            response_o,
  input  wire logic                  debug_halt_i,
  output logic                       irq_o,
  output logic                       sys_reset_o
);
  import wdtts_pkg::*;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDTTS_IDLE = 2'b01,
    WDTTS_DONE = 2'b10
  } wdtts_bus_type;

  wdtts_req_type req;
  wdtts_bus_type bus_state;
  wdtts_bus_type next_bus_state;
  logic          acc;
  logic          wr_go;
  logic          rd_go;

  assign req = '{read: read_i, write: write_i, address: address_i,
                 writedata: writedata_i};
  assign acc = req.read | req.write;

  always_comb
  begin
    case (bus_state)
      WDTTS_IDLE: next_bus_state = acc ? WDTTS_DONE : WDTTS_IDLE;
      WDTTS_DONE: next_bus_state = WDTTS_IDLE;
      default:    next_bus_state = WDTTS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      bus_state <= WDTTS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  // One wait cycle, then the access completes
  assign waitrequest_o = acc && (bus_state != WDTTS_DONE);
  assign wr_go = req.write && bus_state == WDTTS_DONE;
  assign rd_go = req.read && bus_state == WDTTS_DONE;

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic        locked;
  logic        enable;
  logic        rst_en;
  logic        stall_en;
  logic [31:0] load_value;
  logic        cfg_we;
  logic        load_we;
  logic        ctrl_we;
  logic        full_word;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [31:0] count;
  logic        zero;
  logic        run;
  logic        reload;
  logic [31:0] reload_value;
  logic [1:0]  events;
  logic [1:0]  clears;
  logic        tmo_clear;
  logic        second_tmo;

  assign full_word = &byteenable_i;
  assign cfg_we    = wr_go && !locked;
  assign load_we   = cfg_we && req.address == WDTTS_OFF_LOAD && full_word;
  assign ctrl_we   = cfg_we && req.address == WDTTS_OFF_CTRL
                     && byteenable_i[0];

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      locked <= 1'b0;
    else if (wr_go && req.address == WDTTS_OFF_LOCK && full_word)
      locked <= (req.writedata != WDTTS_UNLOCK_KEY);
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      load_value <= WDTTS_LOAD_RST;
    else if (load_we)
      load_value <= req.writedata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      enable   <= 1'b0;
      rst_en   <= 1'b0;
      stall_en <= 1'b0;
    end
    else if (ctrl_we)
    begin
      // Enable can only be set; cleared by reset alone
      enable   <= enable | req.writedata[WDTTS_CTRL_EN_BIT];
      rst_en   <= req.writedata[WDTTS_CTRL_RSTEN_BIT];
      stall_en <= req.writedata[WDTTS_CTRL_STALL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  assign run = enable && !(stall_en && debug_halt_i);
  assign tmo_clear = wr_go && req.address == WDTTS_OFF_STATUS
                     && byteenable_i[0]
                     && req.writedata[WDTTS_ST_TMO_BIT];
  // Reload on zero, and while enabled on load write or on interrupt clear
  assign reload = (zero)
                  || (load_we && enable)
                  || (tmo_clear && enable);
  // A load write reaches the counter in the same cycle
  assign reload_value = load_we ? req.writedata : load_value;

  wdtts_counter u_counter (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .run_i        (run),
    .load_i       (reload),
    .load_value_i (reload_value),
    .count_o      (count),
    .zero_o       (zero)
  );

  assign second_tmo = zero && status[WDTTS_ST_TMO_BIT];
  assign events[WDTTS_ST_TMO_BIT] = zero
                  || (load_we && req.writedata == 32'h00000000);
  assign events[WDTTS_ST_RST_BIT] = second_tmo && rst_en;
  assign clears[WDTTS_ST_TMO_BIT] = tmo_clear;
  assign clears[WDTTS_ST_RST_BIT] = wr_go
                  && req.address == WDTTS_OFF_STATUS && byteenable_i[0]
                  && req.writedata[WDTTS_ST_RST_BIT];

  logic       irq_any;
  logic [1:0] mask_eff;

  wdtts_irq u_irq (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .event_i   (events),
    .clear_i   (clears),
    .mask_we_i (cfg_we && req.address == WDTTS_OFF_MASK && byteenable_i[0]),
    .mask_d_i  (req.writedata[1:0]),
    .status_o  (status),
    .mask_o    (mask),
    .irq_o     (irq_any)
  );

  // Enabling the counter forces the timeout interrupt on
  assign mask_eff = {mask[WDTTS_ST_RST_BIT],
                     mask[WDTTS_ST_TMO_BIT] | enable};
  assign irq_o = irq_any || |(status & {1'b0, enable});

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      sys_reset_o <= 1'b0;
    else if (second_tmo && rst_en)
      sys_reset_o <= 1'b1;
    else
      sys_reset_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic        next_err;

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (req.address)
      WDTTS_OFF_LOAD:   next_rdata = load_value;
      WDTTS_OFF_VALUE:  next_rdata = count;
      WDTTS_OFF_CTRL:   next_rdata = {29'h0, stall_en, rst_en,
                                      enable};
      WDTTS_OFF_STATUS: next_rdata = {30'h0, status};
      WDTTS_OFF_MASK:   next_rdata = {30'h0, mask_eff};
      WDTTS_OFF_MSTAT:  next_rdata = {30'h0, status & mask_eff};
      WDTTS_OFF_LOCK:   next_rdata = {31'h0, locked};
      default:          next_err   = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      readdata_o <= 32'h00000000;
    else if (req.read && bus_state == WDTTS_IDLE)
      readdata_o <= next_rdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      response_o <= 2'h0;
    else if (acc && bus_state == WDTTS_IDLE)
      response_o <= next_err ? 2'h2 : 2'h0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_zero_hit;
    zero && !status[WDTTS_ST_TMO_BIT] && !load_we;
  endsequence

  a_first_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_zero_hit |=> count == $past(load_value))
    else $error("counter not reloaded at first zero");
  a_load_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (load_we && enable) |=> count == $past(req.writedata))
    else $error("load write not copied to counter");
  a_zero_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (load_we && req.writedata == 32'h0) |=> status[0])
    else $error("zero load did not raise interrupt");
  a_lock_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_go && locked) |=> $stable(load_value) && $stable(rst_en))
    else $error("locked config changed");
  a_unlock_key: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wr_go && req.address == WDTTS_OFF_LOCK && full_word
     && req.writedata == WDTTS_UNLOCK_KEY) |=> !locked)
    else $error("unlock key did not unlock");
  a_stall_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (stall_en && debug_halt_i && !reload) |=> $stable(count))
    else $error("counter moved during stall");
  a_no_stall: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (enable && !stall_en && !reload && count != 32'h0)
    |=> count == $past(count) - 32'h1)
    else $error("counter did not decrement");
  a_second_rst: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (zero && status[0] && rst_en) |=> sys_reset_o && status[1])
    else $error("second timeout did not reset");
  a_no_rst: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (zero && !rst_en) |=> !sys_reset_o)
    else $error("reset asserted while disabled");
  a_clear_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tmo_clear && enable && !load_we) |=> count == $past(load_value))
    else $error("interrupt clear did not reload");
  a_en_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (enable && status[0]) |-> irq_o)
    else $error("enabled timeout not signalled");

  // ----------------------------------------------------------------
  // Handshake, lock, timeout, reload, halt, reset and read-back checks
  // ----------------------------------------------------------------
  sequence s_bus_take;
    acc && bus_state == WDTTS_IDLE;
  endsequence

  sequence s_bus_done;
    !waitrequest_o && bus_state == WDTTS_DONE;
  endsequence

  sequence s_lock_write;
    wr_go && locked;
  endsequence

  a_bus_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_bus_take |-> waitrequest_o ##1 s_bus_done)
    else $error("bus access not completed after one wait state");

  a_lock_mask: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_lock_write |=> $stable(mask))
    else $error("locked interrupt enable changed");

  a_lock_ctrl: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_lock_write |=> $stable(enable) && $stable(stall_en))
    else $error("locked control changed");

  a_first_tmo: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_zero_hit |=> status[WDTTS_ST_TMO_BIT])
    else $error("first zero did not raise timeout");

  a_next_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (zero && !load_we) |=> count == $past(load_value))
    else $error("counter not reloaded at zero");

  a_halt_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (enable && !stall_en && debug_halt_i && !reload && count != 32'h0)
    |=> count == $past(count) - 32'h1)
    else $error("counter stopped in debug halt with stall off");

  a_clear_tmo: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tmo_clear && !events[WDTTS_ST_TMO_BIT])
    |=> !status[WDTTS_ST_TMO_BIT])
    else $error("interrupt clear did not clear timeout");

  a_read_en: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_go && req.address == WDTTS_OFF_CTRL)
    |-> readdata_o[WDTTS_CTRL_EN_BIT] == enable)
    else $error("enable state not read back");

  a_read_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (rd_go && req.address == WDTTS_OFF_VALUE)
    |-> readdata_o == $past(count))
    else $error("live count not read back");

  a_reset_state: assert property (@(posedge clk_i)
    !resetn_i |=> !enable && !locked && !rst_en && !stall_en)
    else $error("reset left the watchdog configured");

endmodule
`default_nettype wire

/* File: verif/wdtts_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wdtts_tb_top;
  import wdtts_pkg::*;
  logic        clk;
  logic        resetn;
  logic        rd;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        halt;
  logic [31:0] rdata;
  logic        wreq;
  logic [1:0]  resp;
  logic        irq;
  logic        sysrst;
  logic [1:0]  last_resp;
  logic [31:0] q;
  logic [31:0] v1;
  logic [31:0] v2;
  int          failures;
  int          n_checks;
  int          cycles;
  int          rst_pulses;

  wdtts_top DUT (.clk_i(clk), .resetn_i(resetn), .read_i(rd), .write_i(wr),
    .address_i(addr), .writedata_i(wdata), .byteenable_i(4'hF),
    .readdata_o(rdata), .waitrequest_o(wreq), .response_o(resp),
    .debug_halt_i(halt), .irq_o(irq), .sys_reset_o(sysrst));

  // --------------------------------------------------------------
  // Clock, pulse count and hang guard
  // --------------------------------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (sysrst === 1'b1) rst_pulses++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
      r         = rdata;
      last_resp = resp;
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset_values();
    rchk(WDTTS_OFF_LOAD, 32'hFFFFFFFF);
    rchk(WDTTS_OFF_CTRL, 32'h0);
    rchk(WDTTS_OFF_LOCK, 32'h0);
    rchk(WDTTS_OFF_STATUS, 32'h0);
    rchk(8'h1C, 32'h0);
    chk({30'h0, last_resp}, 32'h2);
  endtask

  task automatic t_zero_load();
    wreg(WDTTS_OFF_LOAD, 32'h0);
    rchk(WDTTS_OFF_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wreg(WDTTS_OFF_MASK, 32'h1);
    chk_irq(1'b1);
    rchk(WDTTS_OFF_MSTAT, 32'h1);
    wreg(WDTTS_OFF_STATUS, 32'h1);
    chk_irq(1'b0);
    wreg(WDTTS_OFF_MASK, 32'h0);
  endtask

  task automatic t_lock();
    wreg(WDTTS_OFF_LOCK, 32'h0);
    rchk(WDTTS_OFF_LOCK, 32'h1);
    wreg(WDTTS_OFF_CTRL, 32'h3);
    wreg(WDTTS_OFF_LOAD, 32'h14);
    rchk(WDTTS_OFF_CTRL, 32'h0);
    rchk(WDTTS_OFF_LOAD, 32'h0);
    wreg(WDTTS_OFF_MASK, 32'h1);
    rchk(WDTTS_OFF_MASK, 32'h0);
    wreg(WDTTS_OFF_LOCK, WDTTS_UNLOCK_KEY);
    rchk(WDTTS_OFF_LOCK, 32'h0);
    wreg(WDTTS_OFF_LOAD, 32'h14);
    rchk(WDTTS_OFF_LOAD, 32'h14);
    wreg(WDTTS_OFF_CTRL, 32'h2);
    rchk(WDTTS_OFF_CTRL, 32'h2);
    wreg(WDTTS_OFF_CTRL, 32'h0);
    rchk(WDTTS_OFF_CTRL, 32'h0);
  endtask

  task automatic t_running();
    wreg(WDTTS_OFF_CTRL, 32'h1);
    rchk(WDTTS_OFF_CTRL, 32'h1);
    rchk(WDTTS_OFF_MASK, 32'h1);
    wreg(WDTTS_OFF_LOAD, 32'h3E8);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    chk({31'h0, v1 <= 32'h3E8 && v1 >= 32'h3DE}, 32'h1);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v2);
    chk({31'h0, v2 < v1}, 32'h1);
  endtask

  task automatic t_stall();
    wreg(WDTTS_OFF_CTRL, 32'h5);
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v2);
    chk(v2, v1);
    halt <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    chk({31'h0, v1 < v2}, 32'h1);
    wreg(WDTTS_OFF_CTRL, 32'h1);
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v2);
    chk({31'h0, v2 < v1}, 32'h1);
    halt <= 1'b0;
  endtask

  task automatic t_expiry();
    wreg(WDTTS_OFF_STATUS, 32'h3);
    wreg(WDTTS_OFF_LOAD, 32'h1E);
    wait_irq();
    rchk(WDTTS_OFF_STATUS, 32'h1);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    chk({31'h0, v1 <= 32'h1E && v1 >= 32'h14}, 32'h1);
    repeat (70) @(posedge clk);
    chk(rst_pulses, 32'h0);
    wreg(WDTTS_OFF_STATUS, 32'h1);
    chk_irq(1'b0);
    bus(1'b0, WDTTS_OFF_VALUE, 32'h0, v1);
    chk({31'h0, v1 <= 32'h1E && v1 >= 32'h1A}, 32'h1);
  endtask

  task automatic t_second();
    wreg(WDTTS_OFF_CTRL, 32'h3);
    wait_irq();
    wreg(WDTTS_OFF_STATUS, 32'h1);
    wait_irq();
    wreg(WDTTS_OFF_STATUS, 32'h1);
    chk(rst_pulses, 32'h0);
    wait_irq();
    repeat (45) @(posedge clk);
    chk(rst_pulses, 32'h1);
    bus(1'b0, WDTTS_OFF_STATUS, 32'h0, q);
    chk(q & 32'h2, 32'h2);
  endtask

  task automatic t_rereset();
    wreg(WDTTS_OFF_LOCK, 32'h0);
    do_reset();
    rchk(WDTTS_OFF_CTRL, 32'h0);
    rchk(WDTTS_OFF_LOCK, 32'h0);
    chk({31'h0, sysrst}, 32'h0);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    halt = 1'b0;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    rst_pulses = 0;
    do_reset();
    t_reset_values();
    t_zero_load();
    t_lock();
    t_running();
    t_stall();
    t_expiry();
    t_second();
    t_rereset();
    report_and_stop();
  end
endmodule
`default_nettype wire
